// File: core/literal_subtractor.sv
// Combinational literal minus accumulator with status flags
`timescale 1ns/1ps
`default_nettype none

module literal_subtractor (
	input  wire logic [7:0] literal,
	input  wire logic [7:0] acc,
	output logic      [7:0] result,
	output logic      [4:0] flags
);

	logic [8:0] sum;
	logic [4:0] low_sum;

	// ------------------------------------------------------------
	// Two's complement add of the inverted accumulator
	// ------------------------------------------------------------
	always_comb begin
		sum     = {1'b0, literal} + {1'b0, ~acc} + 9'h001;
		low_sum = {1'b0, literal[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
		result  = sum[7:0];
		flags   = 5'h00;
		flags[subtract_literal_pkg::FLG_C]  = sum[8];
		flags[subtract_literal_pkg::FLG_DC] = low_sum[4];
		flags[subtract_literal_pkg::FLG_OV] = (literal[7] != acc[7]) && (sum[7] != literal[7]);
		flags[subtract_literal_pkg::FLG_Z]  = (sum[7:0] == 8'h00);
		flags[subtract_literal_pkg::FLG_N]  = sum[7];
	end

endmodule

`default_nettype wire

// File: core/phase_sequencer.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none

module phase_sequencer (
	input  wire logic                          clk_sys,
	input  wire logic                          sys_rst,
	input  wire logic                          start,
	output subtract_literal_pkg::phase_e       phase,
	output logic                               busy
);

	typedef struct packed {
		subtract_literal_pkg::phase_e phase;
		logic                         busy;
	} seq_s;

	seq_s state_q;
	seq_s state_d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q.phase)
			subtract_literal_pkg::PH_IDLE: begin
				if (start) begin
					state_d.phase = subtract_literal_pkg::PH_Q1;
					state_d.busy  = 1'b1;
				end
			end
			subtract_literal_pkg::PH_Q1: state_d.phase = subtract_literal_pkg::PH_Q2;
			subtract_literal_pkg::PH_Q2: state_d.phase = subtract_literal_pkg::PH_Q3;
			subtract_literal_pkg::PH_Q3: state_d.phase = subtract_literal_pkg::PH_Q4;
			subtract_literal_pkg::PH_Q4: begin
				state_d.phase = subtract_literal_pkg::PH_IDLE;
				state_d.busy  = 1'b0;
			end
			// Unused codes fall back to idle
			default: begin
				state_d.phase = subtract_literal_pkg::PH_IDLE;
				state_d.busy  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= '{phase: subtract_literal_pkg::PH_IDLE, busy: 1'b0};
		end else begin
			state_q <= state_d;
		end
	end

	assign phase = state_q.phase;
	assign busy  = state_q.busy;

endmodule

`default_nettype wire

// File: core/subtract_acc_from_literal.sv
// Accumulator datapath executing literal minus accumulator, Avalon-MM slave
//
// Notes on behaviour
// - Take an 8-bit literal and compute literal minus accumulator, 8 bits.
// - Write the difference into the accumulator only, never a file register.
// - Literal above accumulator: carry set, zero and negative cleared; the code takes negative from result bit 7 (set for FFh minus 00h).
// - Equal operands: store 00h, set zero and carry, clear negative.
// - Accumulator above literal: wrapped result, carry cleared, negative set; the code takes negative from result bit 7 (clear for 00h minus FFh).
// - One instruction cycle: decode, literal read, process, write back.
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module subtract_acc_from_literal (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic      [7:0]  acc_value,
	output logic             carry_flag,
	output logic             nibble_carry_flag,
	output logic             zero_flag,
	output logic             signed_wrap_flag,
	output logic             negative_flag,
	output logic             busy
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic        waitreq;
		logic [31:0] rdata;
		logic [15:0] instr;
		logic [7:0]  operand;
		logic [7:0]  result;
		logic [4:0]  res_flags;
		logic [7:0]  acc;
		logic [4:0]  flags;
		logic        bad_op;
		logic [15:0] count;
	} core_s;

	core_s state_q;
	core_s state_d;

	subtract_literal_pkg::phase_e phase;
	logic                         seq_busy;
	logic                         start;
	logic [7:0]                   alu_result;
	logic [4:0]                   alu_flags;
	logic                         req;
	logic                         accept;
	logic                         ack;
	logic                         wr_ack;
	logic                         opcode_ok;
	logic [31:0]                  read_word;
	logic [31:0]                  ctrl_word;

	// ------------------------------------------------------------
	// Sub-blocks
	// ------------------------------------------------------------
	phase_sequencer u_seq (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.start   (start),
		.phase   (phase),
		.busy    (seq_busy)
	);

	literal_subtractor u_alu (
		.literal (state_q.operand),
		.acc     (state_q.acc),
		.result  (alu_result),
		.flags   (alu_flags)
	);

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	// Writes stall while an instruction runs, so software cannot
	// change the accumulator under the datapath; reads never stall.
	always_comb begin
		req    = avs_read || avs_write;
		ack    = req && !state_q.waitreq;
		wr_ack = avs_write && !state_q.waitreq;
		accept = req && state_q.waitreq && !(avs_write && (seq_busy || start));
	end

	always_comb begin
		opcode_ok = (avs_writedata[subtract_literal_pkg::OP_MSB:subtract_literal_pkg::OP_LSB]
			== subtract_literal_pkg::OPCODE_SUB_LIT);
	end

	// Execution starts on the edge that completes the instruction write
	always_comb begin
		start = wr_ack && (avs_address == subtract_literal_pkg::OFS_INSTR)
			&& avs_byteenable[0] && avs_byteenable[1] && opcode_ok;
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		ctrl_word = subtract_literal_pkg::RST_WORD;
		ctrl_word[subtract_literal_pkg::CTL_BUSY]   = seq_busy;
		ctrl_word[subtract_literal_pkg::CTL_BAD_OP] = state_q.bad_op;
		ctrl_word[subtract_literal_pkg::CTL_PH_MSB:subtract_literal_pkg::CTL_PH_LSB] = phase;
		ctrl_word[subtract_literal_pkg::CTL_CNT_MSB:subtract_literal_pkg::CTL_CNT_LSB] =
			state_q.count;
	end

	always_comb begin
		read_word = subtract_literal_pkg::RST_WORD;
		unique case (avs_address)
			subtract_literal_pkg::OFS_INSTR:  read_word[15:0] = state_q.instr;
			subtract_literal_pkg::OFS_ACC:    read_word[7:0]  = state_q.acc;
			subtract_literal_pkg::OFS_STATUS: read_word[4:0]  = state_q.flags;
			subtract_literal_pkg::OFS_CTRL:   read_word       = ctrl_word;
			// Unmapped addresses read as zero
			default:                          read_word       = subtract_literal_pkg::RST_WORD;
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;

		// One-cycle acknowledge, read data captured with it
		if (ack) begin
			state_d.waitreq = 1'b1;
		end else if (accept) begin
			state_d.waitreq = 1'b0;
			state_d.rdata   = avs_read ? read_word : state_q.rdata;
		end

		// Software writes take effect only on the acknowledge edge
		if (wr_ack) begin
			unique case (avs_address)
				subtract_literal_pkg::OFS_INSTR: begin
					if (avs_byteenable[0]) begin
						state_d.instr[7:0] = avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						state_d.instr[15:8] = avs_writedata[15:8];
					end
				end
				subtract_literal_pkg::OFS_ACC: begin
					if (avs_byteenable[0]) begin
						state_d.acc = avs_writedata[7:0];
					end
				end
				subtract_literal_pkg::OFS_STATUS: begin
					if (avs_byteenable[0]) begin
						state_d.flags = avs_writedata[subtract_literal_pkg::FLG_W-1:0];
					end
				end
				subtract_literal_pkg::OFS_CTRL: begin
					if (avs_byteenable[0] && avs_writedata[subtract_literal_pkg::CTL_BAD_OP]) begin
						state_d.bad_op = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// A rejected opcode sets the sticky flag; set beats clear
		if (wr_ack && (avs_address == subtract_literal_pkg::OFS_INSTR) && !start) begin
			state_d.bad_op = 1'b1;
		end

		// four phases of one instruction cycle
		unique case (phase)
			subtract_literal_pkg::PH_IDLE: begin
			end
			subtract_literal_pkg::PH_Q1: begin
				// Decode already done when the instruction write was acknowledged
			end
			subtract_literal_pkg::PH_Q2: begin
				state_d.operand = state_q.instr[subtract_literal_pkg::LIT_MSB:
					subtract_literal_pkg::LIT_LSB];
			end
			subtract_literal_pkg::PH_Q3: begin
				state_d.result    = alu_result;
				state_d.res_flags = alu_flags;
			end
			subtract_literal_pkg::PH_Q4: begin
				state_d.acc   = state_q.result;
				state_d.flags = state_q.res_flags;
				state_d.count = state_q.count + 16'h0001;
			end
			default: begin
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= '{
				waitreq:   1'b1,
				rdata:     subtract_literal_pkg::RST_WORD,
				instr:     subtract_literal_pkg::RST_INSTR,
				operand:   subtract_literal_pkg::RST_ACC,
				result:    subtract_literal_pkg::RST_ACC,
				res_flags: subtract_literal_pkg::RST_FLAGS,
				acc:       subtract_literal_pkg::RST_ACC,
				flags:     subtract_literal_pkg::RST_FLAGS,
				bad_op:    1'b0,
				count:     subtract_literal_pkg::RST_COUNT
			};
		end else begin
			state_q <= state_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign avs_readdata      = state_q.rdata;
	assign avs_waitrequest   = state_q.waitreq;
	assign acc_value         = state_q.acc;
	assign carry_flag        = state_q.flags[subtract_literal_pkg::FLG_C];
	assign nibble_carry_flag = state_q.flags[subtract_literal_pkg::FLG_DC];
	assign zero_flag         = state_q.flags[subtract_literal_pkg::FLG_Z];
	assign signed_wrap_flag  = state_q.flags[subtract_literal_pkg::FLG_OV];
	assign negative_flag     = state_q.flags[subtract_literal_pkg::FLG_N];
	assign busy              = seq_busy;

endmodule

`default_nettype wire

// File: include/subtract_literal_pkg.sv
// Shared constants and types for the literal-minus-accumulator datapath
package subtract_literal_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_INSTR  = 8'h00;
	localparam logic [7:0] OFS_ACC    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_CTRL   = 8'h0C;

	// ------------------------------------------------------------
	// Instruction word
	// ------------------------------------------------------------
	localparam logic [7:0] OPCODE_SUB_LIT = 8'h08;
	localparam int         OP_MSB         = 15;
	localparam int         OP_LSB         = 8;
	localparam int         LIT_MSB        = 7;
	localparam int         LIT_LSB        = 0;

	// ------------------------------------------------------------
	// Status flag bit positions
	// ------------------------------------------------------------
	localparam int FLG_C  = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z  = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_N  = 4;
	localparam int FLG_W  = 5;

	// ------------------------------------------------------------
	// Control register fields
	// ------------------------------------------------------------
	localparam int CTL_BUSY    = 0;
	localparam int CTL_BAD_OP  = 1;
	localparam int CTL_PH_LSB  = 4;
	localparam int CTL_PH_MSB  = 6;
	localparam int CTL_CNT_LSB = 16;
	localparam int CTL_CNT_MSB = 31;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0]  RST_ACC   = 8'h00;
	localparam logic [4:0]  RST_FLAGS = 5'h00;
	localparam logic [15:0] RST_INSTR = 16'h0000;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [31:0] RST_WORD  = 32'h0000_0000;

	// ------------------------------------------------------------
	// Instruction cycle phases, Gray along idle-Q1-Q2-Q3-Q4
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0,
		PH_Q1   = 3'h1,
		PH_Q2   = 3'h3,
		PH_Q3   = 3'h2,
		PH_Q4   = 3'h6
	} phase_e;

endpackage

// File: verif/subtract_acc_from_literal_bench.sv
// Self-checking bench for the literal-minus-accumulator datapath
`timescale 1ns/1ps
`default_nettype none

module subtract_acc_from_literal_bench;
	// ------------------------------------------------------------
	// Stimulus, bus tasks and tests
	// ------------------------------------------------------------
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  acc_value;
	// Five flag ports land on separate bits, so this must be a net
	wire  [4:0]  flg;
	logic        busy;
	logic [31:0] q;
	logic [15:0] cases [8] = '{16'h0201, 16'h0202, 16'h0203, 16'hFF00,
		16'h00FF, 16'h7F80, 16'h8001, 16'h1001};
	int          failures = 0;
	int          n_checks = 0;
	int          n;
	always #12.5 clk_sys = ~clk_sys;
	subtract_acc_from_literal dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.acc_value(acc_value), .carry_flag(flg[0]), .nibble_carry_flag(flg[1]),
		.zero_flag(flg[2]), .signed_wrap_flag(flg[3]), .negative_flag(flg[4]), .busy(busy));
	task automatic conclude();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Request held until waitrequest is sampled low, then released
	task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		int i;
		@(posedge clk_sys);
		avs_address <= ad;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 20) begin
			failures++;
			conclude();
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic wait_done();
		n = 0;
		for (int j = 0; j < 20; j++) begin
			@(negedge clk_sys);
			if (busy === 1'b1) n++;
			else if (n > 0) return;
		end
		failures++;
		conclude();
	endtask
	task automatic run(input logic [7:0] k, input logic [7:0] w);
		logic [7:0] d;
		logic [4:0] f;
		d = k - w;
		f = {d[7], (k[7] != w[7]) && (d[7] != k[7]), d == 8'h00, k[3:0] >= w[3:0], k >= w};
		bus(1'b1, subtract_literal_pkg::OFS_ACC, {24'h00_0000, w});
		bus(1'b1, subtract_literal_pkg::OFS_INSTR, {16'h0000, 8'h08, k});
		wait_done();
		check("busy_cycles", n, 4);
		check("acc_port", acc_value, d);
		check("flag_ports", flg, f);
		bus(1'b0, subtract_literal_pkg::OFS_ACC, 32'h0000_0000);
		check("acc_reg", q, {24'h00_0000, d});
		bus(1'b0, subtract_literal_pkg::OFS_STATUS, 32'h0000_0000);
		check("status_reg", q, {27'h000_0000, f});
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		for (int a = 0; a < 16; a += 4) begin
			bus(1'b0, 8'(a), 32'h0000_0000);
			check("reset_reg", q, 32'h0000_0000);
		end
		$display("test reset done");
		foreach (cases[c]) run(cases[c][15:8], cases[c][7:0]);
		$display("test arithmetic done");
		// Second instruction is stalled while the first runs
		bus(1'b1, 8'h04, 32'h0000_0005);
		bus(1'b1, 8'h00, 32'h0000_0809);
		bus(1'b1, 8'h00, 32'h0000_0810);
		wait_done();
		check("chained_acc", acc_value, 8'h0C);
		$display("test back-to-back done");
		bus(1'b1, 8'h00, 32'h0000_0905);
		repeat (6) @(negedge clk_sys);
		check("bad_busy", busy, 1'b0);
		check("bad_acc", acc_value, 8'h0C);
		bus(1'b0, 8'h0C, 32'h0000_0000);
		check("ctrl_bad", q, 32'h000A_0002);
		bus(1'b1, 8'h0C, 32'h0000_0002);
		bus(1'b0, 8'h0C, 32'h0000_0000);
		check("ctrl_clear", q, 32'h000A_0000);
		// Upper lane off: low byte lands, no execution, sticky flag set
		avs_byteenable <= 4'h1;
		bus(1'b1, 8'h00, 32'h0000_0807);
		avs_byteenable <= 4'hF;
		repeat (6) @(negedge clk_sys);
		check("lane_busy", busy, 1'b0);
		check("lane_acc", acc_value, 8'h0C);
		bus(1'b0, 8'h0C, 32'h0000_0000);
		check("lane_bad", q, 32'h000A_0002);
		bus(1'b0, 8'h00, 32'h0000_0000);
		check("lane_instr", q, 32'h0000_0907);
		$display("test bad opcode done");
		bus(1'b1, 8'h10, 32'hFFFF_FFFF);
		bus(1'b0, 8'h10, 32'h0000_0000);
		check("unmapped", q, 32'h0000_0000);
		$display("test unmapped done");
		conclude();
	end
endmodule
`default_nettype wire

// File: verif/subtract_literal_monitor.sv
// Assertion checker for the literal-minus-accumulator datapath
`timescale 1ns/1ps
`default_nettype none

module subtract_literal_monitor (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic        avs_waitrequest,
	input wire logic [7:0]  acc_value,
	input wire logic        carry_flag,
	input wire logic        nibble_carry_flag,
	input wire logic        zero_flag,
	input wire logic        signed_wrap_flag,
	input wire logic        negative_flag,
	input wire logic        busy
);
	// ------------------------------------------------------------
	// Operand capture and properties
	// ------------------------------------------------------------
	logic [7:0] lit_q;
	logic [7:0] old_q;
	logic       wr_instr;
	// Accumulator is sampled when the instruction write is acknowledged; it cannot change until write-back
	assign wr_instr = avs_write && !avs_waitrequest
		&& avs_address == subtract_literal_pkg::OFS_INSTR;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			lit_q <= 8'h00;
			old_q <= 8'h00;
		end else if (wr_instr) begin
			lit_q <= avs_writedata[7:0];
			old_q <= acc_value;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	diff_value_a: assert property ($fell(busy) |-> acc_value == 8'(lit_q - old_q))
		else $error("accumulator differs from literal minus old accumulator");
	acc_hold_a: assert property (busy |=> $stable(acc_value) || !busy)
		else $error("accumulator changed before write-back");
	carry_set_a: assert property ($fell(busy) |-> carry_flag == (lit_q >= old_q))
		else $error("carry flag wrong");
	zero_flag_a: assert property ($fell(busy) |-> zero_flag == (acc_value == 8'h00))
		else $error("zero flag wrong");
	neg_flag_a: assert property ($fell(busy) |-> negative_flag == acc_value[7])
		else $error("negative flag wrong");
	busy_four_a: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
		else $error("busy did not last four cycles");
	op_start_a: assert property (wr_instr && avs_byteenable[1:0] == 2'b11
		&& avs_writedata[15:8] == subtract_literal_pkg::OPCODE_SUB_LIT |=> $rose(busy))
		else $error("valid instruction did not start");
	op_bad_a: assert property (wr_instr
		&& avs_writedata[15:8] != subtract_literal_pkg::OPCODE_SUB_LIT |=> !busy)
		else $error("foreign opcode started execution");
	aux_flags_a: assert property ($fell(busy) |->
		nibble_carry_flag == (lit_q[3:0] >= old_q[3:0]) && signed_wrap_flag ==
		((lit_q[7] != old_q[7]) && (acc_value[7] != lit_q[7])))
		else $error("nibble or wrap flag wrong");
	cover property ($fell(busy) && zero_flag);
	cover property ($fell(busy) && !carry_flag);
	cover property ($fell(busy) && carry_flag && !zero_flag);
endmodule

bind subtract_acc_from_literal subtract_literal_monitor mon_u (.clk_sys(clk_sys),
	.sys_rst(sys_rst), .avs_address(avs_address), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .acc_value(acc_value), .carry_flag(carry_flag),
	.nibble_carry_flag(nibble_carry_flag), .zero_flag(zero_flag),
	.signed_wrap_flag(signed_wrap_flag), .negative_flag(negative_flag), .busy(busy));
`default_nettype wire
